// ==== scc_serial_crc.sv ====
// Serial character CRC accumulator with a classic Wishbone register slave
//
// Operation
// - Characters go in one bit at a time, LSB first, one right shift each.
// - Each bit shifts right; polynomial is XORed in when feedback is one.
// - Polynomial 8408 hex gives the standard reflected sixteen-bit checksum.
// - Polynomial and width up to 8 held until the next valid configure.
// - Configure reports status 1 for bad polynomial or width, else 0.
// - Preset loads the check register with the host value cut to twice the width, usually zero.
// - Bits above the width are dropped; exactly width bits are shifted.
// - The submitted character reads back unchanged.
// - Register is never cleared between characters of a message.
// - Result reads as two words, each as wide as the character.
// - Low word is presented first, ahead of the high word.
`timescale 1ns/1ps
module scc_serial_crc
  import scc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  scc_bus_e bus_q;
  scc_bus_e bus_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [15:0] poly_q;
  logic [15:0] poly_d;
  logic [3:0] width_q;
  logic [3:0] width_d;
  logic cfg_err_q;
  logic cfg_err_d;
  logic [7:0] char_q;
  logic [7:0] char_d;
  logic fetch_hi_q;
  logic fetch_hi_d;

  logic req;
  logic blockable;
  logic go;
  logic eng_busy;
  logic [15:0] eng_crc;
  logic eng_start;
  logic eng_preset;
  logic [15:0] preset_val;
  logic [31:0] preset_img;
  logic [31:0] cfg_img;
  logic [31:0] cfg_new;
  logic [15:0] cand_poly;
  logic [3:0] cand_width;
  logic cand_bad;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic [31:0] sts_img;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-lane merge for partial Wishbone writes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // A width of zero or above eight, or a polynomial that is zero or
  // reaches past twice the width, cannot describe a CRC
  function automatic logic cfg_invalid(
    input logic [15:0] p,
    input logic [3:0] w
  );
    logic bad;
    bad = 1'b0;
    if (w == 4'h0) begin
      bad = 1'b1;
    end
    if (w > 4'(MAX_CHAR_W)) begin
      bad = 1'b1;
    end
    if (p == 16'h0000) begin
      bad = 1'b1;
    end
    if ((p & ~crc_mask(w)) != 16'h0000) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  scc_crc_engine u_engine (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_preset(eng_preset),
    .i_preset_val(preset_val),
    .i_start(eng_start),
    .i_char(char_d),
    .i_width(width_q),
    .i_poly(poly_q),
    .o_busy(eng_busy),
    .o_crc(eng_crc)
  );

  // ----------------------------------------
  // Views of the state
  // ----------------------------------------
  always_comb begin
    cfg_img = RD_ZERO;
    cfg_img[CFG_POLY_LSB +: 16] = poly_q;
    cfg_img[CFG_WIDTH_LSB +: 4] = width_q;
    cfg_new = lane_merge(cfg_img, i_wb_dat, i_wb_sel);
    cand_poly = cfg_new[CFG_POLY_LSB +: 16];
    cand_width = cfg_new[CFG_WIDTH_LSB +: 4];
    cand_bad = cfg_invalid(cand_poly, cand_width);
    preset_img = lane_merge({16'h0000, eng_crc}, i_wb_dat, i_wb_sel);
    preset_val = preset_img[15:0];
    // Upper word is the register shifted down by one width
    res_lo = eng_crc[7:0] & char_mask(width_q);
    res_hi = 8'(eng_crc >> width_q) & char_mask(width_q);
    sts_img = RD_ZERO;
    sts_img[STS_CFG_ERR_BIT] = cfg_err_q;
    sts_img[STS_BUSY_BIT] = eng_busy;
    sts_img[STS_FETCH_HI_BIT] = fetch_hi_q;
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  // Anything touching the CRC or its settings waits for the engine,
  // so a result is never read half-shifted and settings never change
  // under a running character
  always_comb begin
    req = i_wb_cyc & i_wb_stb;
    case (i_wb_adr)
      OFS_CONFIG: begin
        blockable = 1'b1;
      end
      OFS_PRESET: begin
        blockable = 1'b1;
      end
      OFS_CHAR: begin
        blockable = 1'b1;
      end
      OFS_RES_LO: begin
        blockable = 1'b1;
      end
      OFS_RES_HI: begin
        blockable = 1'b1;
      end
      OFS_FETCH: begin
        blockable = 1'b1;
      end
      default: begin
        blockable = 1'b0;
      end
    endcase
    go = 1'b0;
    if (req && (bus_q != SCC_BUS_ACK)) begin
      go = !(blockable && eng_busy);
    end
  end

  // ----------------------------------------
  // Bus handshake next state
  // ----------------------------------------
  always_comb begin
    bus_d = bus_q;
    ack_d = 1'b0;
    case (bus_q)
      SCC_BUS_IDLE: begin
        if (go) begin
          ack_d = 1'b1;
          bus_d = SCC_BUS_ACK;
        end else if (req) begin
          bus_d = SCC_BUS_WAIT;
        end
      end
      SCC_BUS_WAIT: begin
        if (go) begin
          ack_d = 1'b1;
          bus_d = SCC_BUS_ACK;
        end else if (!req) begin
          bus_d = SCC_BUS_IDLE;
        end
      end
      SCC_BUS_ACK: begin
        // One idle cycle lets the master drop its strobe
        bus_d = SCC_BUS_IDLE;
      end
      default: begin
        bus_d = SCC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_q <= SCC_BUS_IDLE;
      ack_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      ack_q <= ack_d;
    end
  end

  // ----------------------------------------
  // Register file next state
  // ----------------------------------------
  always_comb begin
    poly_d = poly_q;
    width_d = width_q;
    cfg_err_d = cfg_err_q;
    char_d = char_q;
    fetch_hi_d = fetch_hi_q;
    rdat_d = rdat_q;
    eng_start = 1'b0;
    eng_preset = 1'b0;
    if (go && i_wb_we) begin
      case (i_wb_adr)
        OFS_CONFIG: begin
          cfg_err_d = cand_bad;
          fetch_hi_d = 1'b0;
          if (!cand_bad) begin
            poly_d = cand_poly;
            width_d = cand_width;
          end
        end
        OFS_PRESET: begin
          eng_preset = 1'b1;
          fetch_hi_d = 1'b0;
        end
        OFS_CHAR: begin
          // The low lane carries the character; without it nothing runs
          if (i_wb_sel[0]) begin
            char_d = i_wb_dat[7:0];
            eng_start = 1'b1;
            fetch_hi_d = 1'b0;
          end
        end
        OFS_FETCH: begin
          fetch_hi_d = 1'b0;
        end
        default: begin
          fetch_hi_d = fetch_hi_q;
        end
      endcase
    end
    if (go && !i_wb_we) begin
      case (i_wb_adr)
        OFS_CONFIG: begin
          rdat_d = cfg_img;
        end
        OFS_CHAR: begin
          rdat_d = {24'h00_0000, char_q};
        end
        OFS_RES_LO: begin
          rdat_d = {24'h00_0000, res_lo};
        end
        OFS_RES_HI: begin
          rdat_d = {24'h00_0000, res_hi};
        end
        OFS_FETCH: begin
          // Low word first, then high word, then low again
          rdat_d = {24'h00_0000, fetch_hi_q ? res_hi : res_lo};
          fetch_hi_d = !fetch_hi_q;
        end
        OFS_STATUS: begin
          rdat_d = sts_img;
        end
        default: begin
          rdat_d = RD_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      poly_q <= RST_POLY;
      width_q <= RST_WIDTH;
      cfg_err_q <= 1'b0;
      char_q <= RST_CHAR;
      fetch_hi_q <= 1'b0;
      rdat_q <= RD_ZERO;
    end else begin
      poly_q <= poly_d;
      width_q <= width_d;
      cfg_err_q <= cfg_err_d;
      char_q <= char_d;
      fetch_hi_q <= fetch_hi_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_wb_dat = rdat_q;
  assign o_wb_ack = ack_q;

endmodule // scc_serial_crc

// ==== scc_pkg.sv ====
// Package: offsets, fields, reset values, states and helpers of the serial CRC block
package scc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned MAX_CHAR_W = 8;
  localparam int unsigned CRC_W = 16;
  localparam int unsigned WB_DW = 32;
  localparam int unsigned WB_AW = 8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_CHAR = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0c;
  localparam logic [7:0] OFS_RES_HI = 8'h10;
  localparam logic [7:0] OFS_FETCH = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CFG_POLY_LSB = 0;
  localparam int unsigned CFG_WIDTH_LSB = 16;
  localparam int unsigned STS_CFG_ERR_BIT = 0;
  localparam int unsigned STS_BUSY_BIT = 1;
  localparam int unsigned STS_FETCH_HI_BIT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_POLY = 16'h8408;
  localparam logic [3:0] RST_WIDTH = 4'h8;
  localparam logic [15:0] RST_CRC = 16'h0000;
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [0:0] {
    SCC_ENG_IDLE = 1'b0,
    SCC_ENG_SHIFT = 1'b1
  } scc_eng_e;

  typedef enum logic [1:0] {
    SCC_BUS_IDLE = 2'b00,
    SCC_BUS_ACK = 2'b01,
    SCC_BUS_WAIT = 2'b10
  } scc_bus_e;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] char_mask(input logic [3:0] w);
    logic [15:0] m;
    m = (16'h0001 << w) - 16'h0001;
    return m[7:0];
  endfunction

  function automatic logic [15:0] crc_mask(input logic [3:0] w);
    logic [4:0] l;
    logic [16:0] m;
    l = {w, 1'b0};
    m = (17'h00001 << l) - 17'h00001;
    return m[15:0];
  endfunction

endpackage

// ==== scc_crc_engine.sv ====
// Bit-serial CRC shift engine, one character bit per clock
`timescale 1ns/1ps
module scc_crc_engine
  import scc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_preset,
  input wire logic [15:0] i_preset_val,
  input wire logic i_start,
  input wire logic [7:0] i_char,
  input wire logic [3:0] i_width,
  input wire logic [15:0] i_poly,
  output logic o_busy,
  output logic [15:0] o_crc
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  scc_eng_e state_q;
  scc_eng_e state_d;
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic [7:0] bits_q;
  logic [7:0] bits_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic fb;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    crc_d = crc_q;
    bits_d = bits_q;
    cnt_d = cnt_q;
    fb = crc_q[0] ^ bits_q[0];
    case (state_q)
      SCC_ENG_IDLE: begin
        if (i_preset) begin
          crc_d = i_preset_val & crc_mask(i_width);
        end else if (i_start) begin
          bits_d = i_char & char_mask(i_width);
          cnt_d = i_width;
          state_d = SCC_ENG_SHIFT;
        end
      end
      SCC_ENG_SHIFT: begin
        // Register shifts right with zero in at the top; polynomial only when the feedback bit is one
        crc_d = ((crc_q >> 1) ^ (fb ? i_poly : 16'h0000)) & crc_mask(i_width);
        bits_d = bits_q >> 1;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          state_d = SCC_ENG_IDLE;
        end
      end
      default: begin
        state_d = SCC_ENG_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= SCC_ENG_IDLE;
      crc_q <= RST_CRC;
      bits_q <= RST_CHAR;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      crc_q <= crc_d;
      bits_q <= bits_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_busy = (state_q == SCC_ENG_SHIFT);
  assign o_crc = crc_q;

endmodule // scc_crc_engine

// ==== scc_serial_crc_props.sv ====
// Checker: bus-level properties of the serial CRC block
`timescale 1ns/1ps
module scc_serial_crc_props
  import scc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack
);
  // ----------------------------------------
  // Reference state, updated at each acked access
  // ----------------------------------------
  logic [15:0] poly_q, poly_d, crc_q, crc_d;
  logic [3:0] wid_q, wid_d, cnt_q, cnt_d;
  logic [7:0] chr_q, chr_d;
  logic err_q, err_d, hi_q, hi_d, fb;
  logic [31:0] mrg;
  logic take, rd, blk;
  assign take = i_wb_cyc && i_wb_stb && o_wb_ack;
  assign rd = take && !i_wb_we;
  assign blk = i_wb_adr inside {OFS_CHAR, OFS_RES_LO, OFS_RES_HI, OFS_FETCH};

  function automatic logic [15:0] lo_w(input logic [15:0] c, input logic [4:0] w);
    logic [16:0] m;
    m = (17'h00001 << w) - 17'h00001;
    return c & m[15:0];
  endfunction

  always_comb begin
    {poly_d, crc_d, wid_d, chr_d, err_d, hi_d} = {poly_q, crc_q, wid_q, chr_q, err_q, hi_q};
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
    mrg = (i_wb_adr == OFS_PRESET) ? {16'h0000, crc_q} : {12'h000, wid_q, poly_q};
    fb = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (i_wb_sel[b]) mrg[8*b+:8] = i_wb_dat[8*b+:8];
    end
    if (take && i_wb_we && (i_wb_adr inside {OFS_CONFIG, OFS_PRESET, OFS_FETCH}
        || (i_wb_adr == OFS_CHAR && i_wb_sel[0]))) hi_d = 1'b0;
    if (take && i_wb_we && i_wb_adr == OFS_CONFIG) begin
      err_d = (mrg[19:16] == 4'h0) || (mrg[19:16] > 4'h8) || (mrg[15:0] == 16'h0000)
        || ((mrg[15:0] >> {mrg[19:16], 1'b0}) != 16'h0000);
      if (!err_d) {wid_d, poly_d} = mrg[19:0];
    end
    if (take && i_wb_we && i_wb_adr == OFS_PRESET) crc_d = lo_w(mrg[15:0], {wid_q, 1'b0});
    if (take && i_wb_we && i_wb_adr == OFS_CHAR && i_wb_sel[0]) begin
      chr_d = i_wb_dat[7:0];
      cnt_d = wid_q;
      for (int i = 0; i < 8; i++) begin
        if (i < wid_q) begin
          fb = crc_d[0] ^ i_wb_dat[i];
          crc_d = (crc_d >> 1) ^ (fb ? poly_q : 16'h0000);
        end
      end
    end
    if (rd && i_wb_adr == OFS_FETCH) hi_d = !hi_q;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {poly_q, crc_q, wid_q, chr_q, err_q, hi_q, cnt_q} <= {RST_POLY, RST_CRC, RST_WIDTH, RST_CHAR, 2'b00, 4'h0};
    end else begin
      {poly_q, crc_q, wid_q, chr_q, err_q, hi_q, cnt_q} <= {poly_d, crc_d, wid_d, chr_d, err_d, hi_d, cnt_d};
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_cfg_rd;
    rd && i_wb_adr == OFS_CONFIG |-> o_wb_dat == {12'h000, wid_q, poly_q};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_cfg_err;
    rd && i_wb_adr == OFS_STATUS |-> o_wb_dat[STS_CFG_ERR_BIT] == err_q && o_wb_dat[STS_FETCH_HI_BIT] == hi_q;
  endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("status bits wrong");
  property p_char_rd;
    rd && i_wb_adr == OFS_CHAR |-> o_wb_dat == {24'h000000, chr_q};
  endproperty
  a_char_rd: assert property (p_char_rd) else $error("character altered");
  property p_res_lo;
    rd && i_wb_adr == OFS_RES_LO |-> o_wb_dat == {16'h0000, lo_w(crc_q, {1'b0, wid_q})};
  endproperty
  a_res_lo: assert property (p_res_lo) else $error("low result wrong");
  property p_res_hi;
    rd && i_wb_adr == OFS_RES_HI |-> o_wb_dat == {16'h0000, lo_w(crc_q >> wid_q, {1'b0, wid_q})};
  endproperty
  a_res_hi: assert property (p_res_hi) else $error("high result wrong");
  property p_fetch;
    rd && i_wb_adr == OFS_FETCH |-> o_wb_dat == {16'h0000, lo_w(hi_q ? crc_q >> wid_q : crc_q, {1'b0, wid_q})};
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch order wrong");
  // Shifting needs width cycles, so a blocked access cannot finish sooner
  property p_wait;
    rd && blk |-> cnt_q <= 4'h1;
  endproperty
  a_wait: assert property (p_wait) else $error("access answered during shift");
  property p_ack;
    o_wb_ack |-> i_wb_cyc && i_wb_stb ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack without request or too long");
endmodule // scc_serial_crc_props

bind scc_serial_crc scc_serial_crc_props u_props (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));

// ==== scc_host_model.sv ====
// Host model: classic Wishbone master feeding characters to the CRC block
`timescale 1ns/1ps
module scc_host_model
  import scc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_ack,
  input wire logic [31:0] i_dat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [7:0] o_adr,
  output logic [3:0] o_sel,
  output logic [31:0] o_dat
);
  logic tmo = 1'b0;
  logic [3:0] sel_v = 4'hf;
  logic [7:0] line_q[$];
  initial begin
    {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = {3'b000, 8'h00, 4'hf, 32'h0};
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, sel_v, d};
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (i_ack !== 1'b1 && n < 300);
    q = i_dat;
    tmo = tmo | (n >= 300);
    // Released lines flip so a stale request never looks valid
    {o_cyc, o_stb, o_we, o_adr, o_dat} <= {2'b00, ~w, ~a, ~d};
  endtask

  task automatic preset(input logic [15:0] v);
    logic [31:0] q;
    xfer(1'b1, OFS_PRESET, {16'h0000, v}, q);
  endtask

  task automatic send_char(input logic [7:0] c);
    logic [31:0] q;
    xfer(1'b1, OFS_CHAR, {24'h000000, c}, q);
    line_q.push_back(c);
  endtask

  // Low word leaves first, then the high word closes the message
  task automatic append_crc();
    logic [31:0] q;
    xfer(1'b1, OFS_FETCH, 32'h0, q);
    xfer(1'b0, OFS_FETCH, 32'h0, q);
    line_q.push_back(q[7:0]);
    xfer(1'b0, OFS_FETCH, 32'h0, q);
    line_q.push_back(q[7:0]);
  endtask
endmodule // scc_host_model

// ==== scc_serial_crc_bench.sv ====
// Testbench: register-level scenarios for the serial CRC block
`timescale 1ns/1ps
module scc_serial_crc_bench;
  import scc_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, good;
  logic [15:0] c;
  int err_count = 0;
  int compares = 0;
  string msg = "123456789";
  logic [31:0] cfg_tab [6] = '{32'h0009_8408, 32'h0000_8408, 32'h0004_0100, 32'h0004_0000, 32'h0004_0080,
    32'h0008_8408};
  logic err_tab [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  always #2.5 clk_sys = ~clk_sys;

  scc_serial_crc uut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack));
  scc_host_model host (.i_clk_sys(clk_sys), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_sel(sel), .o_dat(wdat));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic finish_test();
    if (host.tmo) err_count++;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q);
    if (host.tmo) finish_test();
  endtask

  function automatic logic [15:0] ref_step(input logic [15:0] r, input logic [7:0] ch, input int w,
    input logic [15:0] p);
    logic f;
    for (int i = 0; i < w; i++) begin
      f = r[0] ^ ch[i];
      r = (r >> 1) ^ (f ? p : 16'h0000);
    end
    return r;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    good = 32'h0008_8408;
    bus(1'b0, OFS_CONFIG, 32'h0);
    `CHK(q, good)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(q, 32'h0)
    // Bad widths and polynomials leave the settings alone
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFS_CONFIG, cfg_tab[i]);
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(q[0], err_tab[i])
      if (!err_tab[i]) good = cfg_tab[i];
      bus(1'b0, OFS_CONFIG, 32'h0);
      `CHK(q, good)
    end
    host.preset(16'h0000);
    for (int i = 0; i < msg.len(); i++) host.send_char(msg[i]);
    bus(1'b0, OFS_RES_LO, 32'h0);
    `CHK(q, 32'h89)
    bus(1'b0, OFS_RES_HI, 32'h0);
    `CHK(q, 32'h21)
    host.append_crc();
    `CHK(host.line_q.size(), 11)
    `CHK(host.line_q[9], 8'h89)
    `CHK(host.line_q[10], 8'h21)
    // The receiver runs the whole line, checksum included, and is left at zero
    host.preset(16'h0000);
    foreach (host.line_q[i]) bus(1'b1, OFS_CHAR, {24'h0, host.line_q[i]});
    bus(1'b0, OFS_RES_LO, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, OFS_RES_HI, 32'h0);
    `CHK(q, 32'h0)
    // Seven-bit characters: top bit dropped, preset cut to fourteen bits
    bus(1'b1, OFS_CONFIG, 32'h0007_2001);
    host.preset(16'hffff);
    host.send_char(8'hff);
    c = ref_step(16'h3fff, 8'hff, 7, 16'h2001);
    bus(1'b0, OFS_CHAR, 32'h0);
    `CHK(q, 32'hff)
    bus(1'b0, OFS_RES_LO, 32'h0);
    `CHK(q, {25'h0, c[6:0]})
    bus(1'b0, OFS_RES_HI, 32'h0);
    `CHK(q, {25'h0, c[13:7]})
    bus(1'b0, OFS_FETCH, 32'h0);
    `CHK(q, {25'h0, c[6:0]})
    bus(1'b0, OFS_FETCH, 32'h0);
    `CHK(q, {25'h0, c[13:7]})
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(q, 32'h0)
    // A character write without its low lane is ignored
    host.sel_v = 4'he;
    bus(1'b1, OFS_CHAR, 32'h0000_0055);
    host.sel_v = 4'hf;
    bus(1'b0, OFS_CHAR, 32'h0);
    `CHK(q, 32'hff)
    // Reset with the engine idle brings back the default settings
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, OFS_CONFIG, 32'h0);
    `CHK(q, 32'h0008_8408)
    bus(1'b0, OFS_RES_LO, 32'h0);
    `CHK(q, 32'h0)
    finish_test();
  end
endmodule // scc_serial_crc_bench
